// ---- ciolr_regs.sv ----
/*
 Input current limit, input voltage floor and reverse-boost limit registers
 with the power management decisions they drive. Assumes measurements in
 mA and mV synchronous to clk, and a host on the two-wire serial port.
*/
`timescale 1ns/1ps
module ciolr_regs
   import ciolr_pkg::*;
(
   input wire logic clk,
   input wire logic reset,
   input wire logic scl_in,
   input wire logic sda_in,
   output logic sda_out,
   output logic sda_oe,
   input ciolr_meas_t meas,
   input wire logic adapter_removed,
   input wire logic input_current_optimizer_active,
   input wire logic [6:0] input_current_optimizer_code,
   input wire logic external_limit_enable,
   input wire logic reverse_boost_low_range,
   input wire logic charge_current_zero,
   output logic [15:0] input_limit_ma,
   output logic [15:0] input_floor_mv,
   output logic [15:0] reverse_boost_mv,
   output logic [15:0] reverse_boost_ma,
   output logic external_limit_active,
   output logic input_voltage_regulation,
   output logic charge_reduce,
   output logic supplement_mode
);
   ciolr_wr_t wr;
   logic [7:0] rd_cmd;
   logic [15:0] rd_data;
   logic [6:0] host_code_reg, eff_code_reg, otg_i_code_reg;
   logic [7:0] floor_code_reg;
   logic [11:0] otg_v_code_reg;
   logic floor_default_reg;
   logic [15:0] lim_ma_reg, floor_mv_reg, otg_mv_reg, otg_ma_reg;
   logic ext_reg, vreg_reg, reduce_reg, supp_reg;

   // ----------------------------------------
   // Serial port
   // ----------------------------------------
   ciolr_word_port u_port (
      .clk(clk),
      .reset(reset),
      .scl_in(scl_in),
      .sda_in(sda_in),
      .sda_out(sda_out),
      .sda_oe(sda_oe),
      .wr(wr),
      .rd_cmd(rd_cmd),
      .rd_data(rd_data)
   );

   // ----------------------------------------
   // Decode
   // ----------------------------------------
   wire wr_host = wr.en && wr.cmd == CIOLR_OFF_HOST_LIM;
   wire wr_floor = wr.en && wr.cmd == CIOLR_OFF_VFLOOR;
   wire wr_otg_v = wr.en && wr.cmd == CIOLR_OFF_OTG_V;
   wire wr_otg_i = wr.en && wr.cmd == CIOLR_OFF_OTG_I;
   wire [6:0] host_clamped = (host_code_reg == 7'h00) ? CIOLR_CODE_MIN : host_code_reg;
   wire [6:0] eff_next = input_current_optimizer_active ?
      input_current_optimizer_code : host_clamped;
   wire [6:0] eff_nz = (eff_code_reg == 7'h00) ? CIOLR_CODE_MIN : eff_code_reg;
   wire [15:0] lim_ma_next = {9'h000, eff_nz} * CIOLR_LIM_STEP_MA;
   wire [15:0] floor_def = (meas.input_bus_voltage_noload_mv > CIOLR_VFLOOR_DEF_OFS_MV) ?
      meas.input_bus_voltage_noload_mv - CIOLR_VFLOOR_DEF_OFS_MV : 16'h0000;
   wire [15:0] floor_code_mv = {2'b00, floor_code_reg, 6'h00};
   wire [15:0] floor_next = floor_default_reg ? floor_def :
      (floor_code_reg == 8'h00) ? CIOLR_VFLOOR_ZERO_MV : floor_code_mv;
   wire [15:0] otg_raw = {1'b0, otg_v_code_reg, 3'b000} +
      (reverse_boost_low_range ? 16'h0000 : CIOLR_OTG_OFS_MV);
   wire [15:0] otg_next = (otg_raw < CIOLR_OTG_MIN_MV) ? CIOLR_OTG_MIN_MV :
      (otg_raw > CIOLR_OTG_MAX_MV) ? CIOLR_OTG_MAX_MV : otg_raw;
   wire [15:0] otg_ma_next = {9'h000, otg_i_code_reg} * CIOLR_LIM_STEP_MA;
   wire ext_next = external_limit_enable && meas.ext_pin_mv <= CIOLR_EXT_PIN_OFF_MV;
   wire vreg_next = meas.input_bus_voltage_mv < floor_mv_reg;
   wire reduce_next = meas.iin_ma > lim_ma_reg || vreg_next;
   wire supp_next = reduce_next && charge_current_zero && meas.vsys_mv < meas.vbat_mv;

   // ----------------------------------------
   // Read mux, reserved bits read zero
   // ----------------------------------------
   always_comb begin
      case (rd_cmd)
         CIOLR_OFF_HOST_LIM: rd_data = {1'b0, host_code_reg, 8'h00};
         CIOLR_OFF_EFF_LIM: rd_data = {1'b0, eff_code_reg, 8'h00};
         CIOLR_OFF_VFLOOR: rd_data = {2'b00, floor_code_reg, 6'h00};
         CIOLR_OFF_OTG_V: rd_data = {2'b00, otg_v_code_reg, 2'b00};
         CIOLR_OFF_OTG_I: rd_data = {1'b0, otg_i_code_reg, 8'h00};
         default: rd_data = 16'h0000;
      endcase
   end

   // ----------------------------------------
   // Registers
   // ----------------------------------------
   always_ff @(posedge clk) begin
      if (reset) begin
         host_code_reg <= CIOLR_HOST_CODE_RST;
         eff_code_reg <= CIOLR_HOST_LIM_RST[14:8];
         floor_code_reg <= CIOLR_VFLOOR_RST;
         floor_default_reg <= 1'b1;
         otg_v_code_reg <= CIOLR_OTG_V_RST;
         otg_i_code_reg <= CIOLR_OTG_I_RST;
      end else begin
         if (adapter_removed) host_code_reg <= CIOLR_HOST_CODE_RST;
         else if (wr_host) host_code_reg <= wr.data[14:8];
         eff_code_reg <= eff_next;
         if (wr_floor) begin
            floor_code_reg <= wr.data[13:6];
            floor_default_reg <= 1'b0;
         end
         if (wr_otg_v) otg_v_code_reg <= wr.data[13:2];
         if (wr_otg_i) otg_i_code_reg <= wr.data[14:8];
      end
   end

   always_ff @(posedge clk) begin
      if (reset) begin
         lim_ma_reg <= 16'h0000;
         floor_mv_reg <= 16'h0000;
         otg_mv_reg <= CIOLR_OTG_MIN_MV;
         otg_ma_reg <= 16'h0000;
         ext_reg <= 1'b0;
         vreg_reg <= 1'b0;
         reduce_reg <= 1'b0;
         supp_reg <= 1'b0;
      end else begin
         lim_ma_reg <= lim_ma_next;
         floor_mv_reg <= floor_next;
         otg_mv_reg <= otg_next;
         otg_ma_reg <= otg_ma_next;
         ext_reg <= ext_next;
         vreg_reg <= vreg_next;
         reduce_reg <= reduce_next;
         supp_reg <= supp_next;
      end
   end

   assign input_limit_ma = lim_ma_reg;
   assign input_floor_mv = floor_mv_reg;
   assign reverse_boost_mv = otg_mv_reg;
   assign reverse_boost_ma = otg_ma_reg;
   assign external_limit_active = ext_reg;
   assign input_voltage_regulation = vreg_reg;
   assign charge_reduce = reduce_reg;
   assign supplement_mode = supp_reg;

   // ----------------------------------------
   // Checks
   // ----------------------------------------
   default clocking cb @(posedge clk); endclocking
   default disable iff (reset);

   // Helpers for checks and covers
   wire [15:0] rd_data_host = {1'b0, host_code_reg, 8'h00};
   logic [6:0] wr_hold_reg;
   always_ff @(posedge clk) begin
      wr_hold_reg <= wr.data[14:8];
   end

   // ----------------------------------------
   // Checks: host and read-back limit, external limit, floor, supplement and boost range
   // ----------------------------------------

   a_limit_scale: assert property (
      eff_code_reg != 7'h00 |=> lim_ma_reg == 16'($past(eff_code_reg)) * 16'd50)
      else $error("input limit not code times 50 mA");
   a_host_clamp: assert property (
      !input_current_optimizer_active && host_code_reg == 7'h00 |=> eff_code_reg == 7'h01)
      else $error("host code zero not clamped to one");
   a_host_reset: assert property ($fell(reset) |-> host_code_reg == 7'h41)
      else $error("host limit reset value wrong");
   a_adapter_gone: assert property (
      adapter_removed |=> host_code_reg == 7'h41 && rd_data_host == 16'h4100)
      else $error("adapter removal did not restore host limit");
   a_ext_off: assert property (
      !external_limit_enable || meas.ext_pin_mv > 16'd4000 |=> !external_limit_active)
      else $error("external limit active while disabled");
   a_ico_follow: assert property (
      input_current_optimizer_active |=> eff_code_reg == $past(input_current_optimizer_code))
      else $error("read-back did not follow optimizer");
   a_zero_50ma: assert property (eff_code_reg == 7'h00 |=> lim_ma_reg == 16'd50)
      else $error("read-back zero not 50 mA");
   a_vin_enter: assert property (
      meas.input_bus_voltage_mv < floor_mv_reg |=> input_voltage_regulation && charge_reduce)
      else $error("no voltage regulation below floor");
   a_floor_zero: assert property (
      wr_floor && wr.data[13:6] == 8'h00 |=> ##1 floor_mv_reg == 16'd3200)
      else $error("floor code zero not 3.2 V");
   a_supp_cause: assert property (
      supplement_mode |-> $past(charge_current_zero) && $past(meas.vsys_mv < meas.vbat_mv))
      else $error("supplement without cause");
   a_otg_clamp: assert property (
      reverse_boost_mv >= 16'd3000 && reverse_boost_mv <= 16'd20560)
      else $error("boost voltage out of range");
   a_low_byte: assert property (
      rd_cmd == CIOLR_OFF_HOST_LIM |-> rd_data[7:0] == 8'h00)
      else $error("host limit low byte not zero");

   a_host_write: assert property (
      wr_host && !adapter_removed |=> host_code_reg == $past(wr.data[14:8]))
      else $error("host limit write not stored");

   a_host_shown: assert property (
      !input_current_optimizer_active && host_code_reg != 7'h00 |=>
      eff_code_reg == $past(host_code_reg))
      else $error("read-back does not show host limit");

   a_ext_on: assert property (
      external_limit_enable && meas.ext_pin_mv <= 16'h0FA0 |=> external_limit_active)
      else $error("external limit off while enabled and low");

   // ----------------------------------------
   // Checks: input voltage floor and overload
   // ----------------------------------------
   a_floor_scale: assert property (
      !floor_default_reg && floor_code_reg != 8'h00 |=>
      input_floor_mv == 16'($past(floor_code_reg)) * 16'h0040)
      else $error("floor not code times 64 mV");

   a_floor_default: assert property (
      floor_default_reg && meas.input_bus_voltage_noload_mv > 16'h0500 |=>
      input_floor_mv == $past(meas.input_bus_voltage_noload_mv) - 16'h0500)
      else $error("default floor not bus minus 1.28 V");

   a_over_current: assert property (
      meas.iin_ma > input_limit_ma |=> charge_reduce)
      else $error("no charge reduction on input overload");

   // ----------------------------------------
   // Checks: reverse boost
   // ----------------------------------------
   a_otg_store: assert property (
      wr_otg_v |=> otg_v_code_reg == $past(wr.data[13:2]))
      else $error("boost voltage code not stored");

   a_otg_offset: assert property (
      !reverse_boost_low_range && otg_v_code_reg > 12'h100 && otg_v_code_reg < 12'h800 |=>
      reverse_boost_mv == 16'($past(otg_v_code_reg)) * 16'h0008 + 16'h0500)
      else $error("boost voltage offset missing");

   a_otg_plain: assert property (
      reverse_boost_low_range && otg_v_code_reg > 12'h177 && otg_v_code_reg < 12'h800 |=>
      reverse_boost_mv == 16'($past(otg_v_code_reg)) * 16'h0008)
      else $error("boost voltage offset in low range");

   a_otg_cap: assert property (
      reverse_boost_ma == 16'($past(otg_i_code_reg)) * 16'h0032)
      else $error("boost current cap not code times 50 mA");

   // ----------------------------------------
   // Covers
   // ----------------------------------------
   c_host_write: cover property (wr_host ##1 host_code_reg == wr_hold_reg);
   c_ico_change: cover property (input_current_optimizer_active ##1 eff_code_reg != host_clamped);
   c_supplement: cover property ($rose(supplement_mode));
   c_vin_reg: cover property ($rose(input_voltage_regulation));
   c_otg_top: cover property (reverse_boost_mv == 16'h5050);
endmodule

// ---- ciolr_pkg.sv ----
/*
 Constants, types and register map of the charger input and reverse-boost
 limit register bank. Assumes a 10 MHz clock and a word-oriented serial host.
*/
package ciolr_pkg;
   // ----------------------------------------
   // Register command codes
   // ----------------------------------------
   localparam logic [7:0] CIOLR_OFF_EFF_LIM = 8'h22;
   localparam logic [7:0] CIOLR_OFF_OTG_V = 8'h3B;
   localparam logic [7:0] CIOLR_OFF_OTG_I = 8'h3C;
   localparam logic [7:0] CIOLR_OFF_VFLOOR = 8'h3D;
   localparam logic [7:0] CIOLR_OFF_HOST_LIM = 8'h3F;
   // ----------------------------------------
   // Field positions and reset values
   // ----------------------------------------
   localparam int CIOLR_LIM_LSB = 8;
   localparam int CIOLR_VFLOOR_LSB = 6;
   localparam int CIOLR_OTG_V_LSB = 2;
   localparam logic [15:0] CIOLR_HOST_LIM_RST = 16'h4100;
   localparam logic [6:0] CIOLR_HOST_CODE_RST = 7'h41;
   localparam logic [6:0] CIOLR_CODE_MIN = 7'h01;
   localparam logic [11:0] CIOLR_OTG_V_RST = 12'h000;
   localparam logic [6:0] CIOLR_OTG_I_RST = 7'h00;
   localparam logic [7:0] CIOLR_VFLOOR_RST = 8'h00;
   // ----------------------------------------
   // Analog scale, in mA and mV
   // ----------------------------------------
   localparam logic [15:0] CIOLR_LIM_STEP_MA = 16'h0032;
   localparam logic [15:0] CIOLR_VFLOOR_DEF_OFS_MV = 16'h0500;
   localparam logic [15:0] CIOLR_VFLOOR_ZERO_MV = 16'h0C80;
   localparam logic [15:0] CIOLR_EXT_PIN_OFF_MV = 16'h0FA0;
   localparam logic [15:0] CIOLR_OTG_OFS_MV = 16'h0500;
   localparam logic [15:0] CIOLR_OTG_MIN_MV = 16'h0BB8;
   localparam logic [15:0] CIOLR_OTG_MAX_MV = 16'h5050;
   // ----------------------------------------
   // Serial port
   // ----------------------------------------
   localparam logic [6:0] CIOLR_DEV_ADDR = 7'h2A; // Arbitrary value
   localparam logic [3:0] CIOLR_ACK_SLOT = 4'h8;
   typedef enum logic [2:0] {
      CIOLR_S_IDLE = 3'b000,
      CIOLR_S_ADDR = 3'b001,
      CIOLR_S_CMD = 3'b011,
      CIOLR_S_WLO = 3'b010,
      CIOLR_S_WHI = 3'b110,
      CIOLR_S_RLO = 3'b111,
      CIOLR_S_RHI = 3'b101,
      CIOLR_S_DONE = 3'b100
   } ciolr_state_t;
   // ----------------------------------------
   // Carriers
   // ----------------------------------------
   typedef struct packed {
      logic en;
      logic [7:0] cmd;
      logic [15:0] data;
   } ciolr_wr_t;
   typedef struct packed {
      logic [15:0] iin_ma;
      logic [15:0] input_bus_voltage_mv;
      logic [15:0] input_bus_voltage_noload_mv;
      logic [15:0] vsys_mv;
      logic [15:0] vbat_mv;
      logic [15:0] ext_pin_mv;
   } ciolr_meas_t;
endpackage

// ---- ciolr_word_port.sv ----
/*
 Serial word slave: write word and read word by command code.
 Assumes scl and sda samples synchronous to clk and slow against it.
*/
`timescale 1ns/1ps
module ciolr_word_port
   import ciolr_pkg::*;
(
   input wire logic clk,
   input wire logic reset,
   input wire logic scl_in,
   input wire logic sda_in,
   output logic sda_out,
   output logic sda_oe,
   output ciolr_wr_t wr,
   output logic [7:0] rd_cmd,
   input wire logic [15:0] rd_data
);
   ciolr_state_t st_reg;
   logic [3:0] bitc_reg;
   logic [7:0] rx_reg, tx_reg, cmd_reg, lo_reg;
   logic scl_q_reg, sda_q_reg, oe_reg, rw_reg, mack_reg;
   ciolr_wr_t wr_reg;

   // ----------------------------------------
   // Line events
   // ----------------------------------------
   wire scl_rise = scl_in && !scl_q_reg;
   wire scl_fall = !scl_in && scl_q_reg;
   wire start_ev = scl_in && scl_q_reg && sda_q_reg && !sda_in;
   wire stop_ev = scl_in && scl_q_reg && !sda_q_reg && sda_in;
   wire ack_end = scl_fall && bitc_reg == CIOLR_ACK_SLOT;
   wire byte_end = scl_fall && bitc_reg == 4'h7;
   wire tx_state = st_reg == CIOLR_S_RLO || st_reg == CIOLR_S_RHI;
   wire addr_hit = rx_reg[7:1] == CIOLR_DEV_ADDR;
   wire ack_now = (st_reg == CIOLR_S_ADDR) ? addr_hit :
      (st_reg == CIOLR_S_CMD || st_reg == CIOLR_S_WLO || st_reg == CIOLR_S_WHI);

   // ----------------------------------------
   // Next state at end of acknowledge slot
   // ----------------------------------------
   ciolr_state_t st_next;
   always_comb begin
      case (st_reg)
         CIOLR_S_ADDR: st_next = !addr_hit ? CIOLR_S_IDLE :
            (rw_reg ? CIOLR_S_RLO : CIOLR_S_CMD);
         CIOLR_S_CMD: st_next = CIOLR_S_WLO;
         CIOLR_S_WLO: st_next = CIOLR_S_WHI;
         CIOLR_S_RLO: st_next = mack_reg ? CIOLR_S_RHI : CIOLR_S_DONE;
         CIOLR_S_WHI, CIOLR_S_RHI: st_next = CIOLR_S_DONE;
         default: st_next = st_reg;
      endcase
   end
   wire [7:0] tx_load = (st_next == CIOLR_S_RLO) ? rd_data[7:0] : rd_data[15:8];

   always_ff @(posedge clk) begin
      if (reset) begin
         st_reg <= CIOLR_S_IDLE;
         bitc_reg <= 4'h0;
         rx_reg <= 8'h00;
         tx_reg <= 8'h00;
         cmd_reg <= 8'h00;
         lo_reg <= 8'h00;
         scl_q_reg <= 1'b1;
         sda_q_reg <= 1'b1;
         oe_reg <= 1'b0;
         rw_reg <= 1'b0;
         mack_reg <= 1'b0;
         wr_reg <= '0;
      end else begin
         scl_q_reg <= scl_in;
         sda_q_reg <= sda_in;
         wr_reg.en <= 1'b0;
         if (start_ev) begin
            st_reg <= CIOLR_S_ADDR;
            bitc_reg <= 4'hF; // Start's own scl fall wraps to zero
            oe_reg <= 1'b0;
         end else if (stop_ev) begin
            st_reg <= CIOLR_S_IDLE;
            oe_reg <= 1'b0;
         end else if (st_reg != CIOLR_S_IDLE) begin
            if (scl_rise && bitc_reg == CIOLR_ACK_SLOT) begin
               mack_reg <= !sda_in;
            end else if (scl_rise) begin
               rx_reg <= {rx_reg[6:0], sda_in};
            end
            if (byte_end) begin
               bitc_reg <= CIOLR_ACK_SLOT;
               oe_reg <= !tx_state && ack_now;
               rw_reg <= rx_reg[0];
               if (st_reg == CIOLR_S_CMD) cmd_reg <= rx_reg;
               if (st_reg == CIOLR_S_WLO) lo_reg <= rx_reg;
               if (st_reg == CIOLR_S_WHI) begin
                  wr_reg <= '{en: 1'b1, cmd: cmd_reg, data: {rx_reg, lo_reg}};
               end
            end else if (ack_end) begin
               bitc_reg <= 4'h0;
               st_reg <= st_next;
               tx_reg <= tx_load;
               oe_reg <= (st_next == CIOLR_S_RLO || st_next == CIOLR_S_RHI) && !tx_load[7];
            end else if (scl_fall) begin
               bitc_reg <= bitc_reg + 4'h1;
               tx_reg <= {tx_reg[6:0], 1'b0};
               oe_reg <= tx_state && !tx_reg[6];
            end
         end
      end
   end

   assign sda_out = 1'b0;
   assign sda_oe = oe_reg;
   assign wr = wr_reg;
   assign rd_cmd = cmd_reg;
endmodule

// ---- ciolr_host.sv ----
/*
 Word host model for the limit register bank: start, byte, ack, stop.
 Assumes a pull-up on sda; the bench resolves the wire from both pull-downs.
*/
`timescale 1ns/1ps
module ciolr_host
   import ciolr_pkg::*;
(
   input wire logic clk,
   input wire logic sda_in,
   output logic scl,
   output logic sda_low
);
   // ----------------------------------------
   // Bit level, 4 clk high and low
   // ----------------------------------------
   initial begin
      scl = 1'b1;
      sda_low = 1'b0;
   end
   task automatic tick(input int n);
      repeat (n) @(posedge clk);
   endtask
   task automatic bit_out(input logic b);
      sda_low <= ~b;
      tick(2);
      scl <= 1'b1;
      tick(4);
      scl <= 1'b0;
      tick(2);
   endtask
   task automatic bit_in(output logic b);
      sda_low <= 1'b0;
      tick(2);
      scl <= 1'b1;
      tick(3);
      b = sda_in;
      tick(1);
      scl <= 1'b0;
      tick(2);
   endtask
   task automatic start();
      tick(1);
      sda_low <= 1'b0;
      tick(2);
      scl <= 1'b1;
      tick(4);
      sda_low <= 1'b1;
      tick(4);
      scl <= 1'b0;
      tick(2);
   endtask
   task automatic stop();
      sda_low <= 1'b1;
      tick(2);
      scl <= 1'b1;
      tick(4);
      sda_low <= 1'b0;
      tick(4);
   endtask
   // ----------------------------------------
   // Byte and word level
   // ----------------------------------------
   task automatic byte_out(input logic [7:0] d, inout logic ok);
      logic a;
      for (int i = 7; i >= 0; i--) begin
         bit_out(d[i]);
      end
      bit_in(a);
      if (a !== 1'b0) begin
         ok = 1'b0;
      end
   endtask
   task automatic byte_in(output logic [7:0] d, input logic last);
      for (int i = 7; i >= 0; i--) begin
         bit_in(d[i]);
      end
      bit_out(last);
   endtask
   task automatic write_word(input logic [7:0] cmd, input logic [15:0] d, output logic ok);
      ok = 1'b1;
      start();
      byte_out({CIOLR_DEV_ADDR, 1'b0}, ok);
      byte_out(cmd, ok);
      byte_out(d[7:0], ok);
      byte_out(d[15:8], ok);
      stop();
   endtask
   task automatic read_word(input logic [7:0] cmd, output logic [15:0] d, output logic ok);
      ok = 1'b1;
      start();
      byte_out({CIOLR_DEV_ADDR, 1'b0}, ok);
      byte_out(cmd, ok);
      start();
      byte_out({CIOLR_DEV_ADDR, 1'b1}, ok);
      byte_in(d[7:0], 1'b0);
      byte_in(d[15:8], 1'b1);
      stop();
   endtask
endmodule

// ---- tb.sv ----
/*
 Self-checking bench of the limit register bank through its serial port.
 Assumes the host model drives scl and pulls sda; sda has a pull-up.
*/
`timescale 1ns/1ps
module tb
   import ciolr_pkg::*;
;
   logic clk, reset, scl, host_low, sda_out, sda_oe, adapter_removed, ico_act;
   logic ext_en, low_rng, chg_zero, ext_act, vreg, chg_red, supp;
   logic [6:0] ico_code;
   logic [15:0] lim_ma, floor_mv, rb_mv, rb_ma;
   ciolr_meas_t meas;
   int n_errors = 0;
   int checks_done = 0;
   wire sda = ~(host_low | (sda_oe & ~sda_out));
   ciolr_regs u_ciolr_regs (.clk(clk), .reset(reset), .scl_in(scl), .sda_in(sda),
      .sda_out(sda_out), .sda_oe(sda_oe), .meas(meas), .adapter_removed(adapter_removed),
      .input_current_optimizer_active(ico_act), .input_current_optimizer_code(ico_code),
      .external_limit_enable(ext_en), .reverse_boost_low_range(low_rng),
      .charge_current_zero(chg_zero), .input_limit_ma(lim_ma), .input_floor_mv(floor_mv),
      .reverse_boost_mv(rb_mv), .reverse_boost_ma(rb_ma), .external_limit_active(ext_act),
      .input_voltage_regulation(vreg), .charge_reduce(chg_red), .supplement_mode(supp));
   ciolr_host u_ciolr_host (.clk(clk), .sda_in(sda), .scl(scl), .sda_low(host_low));
   // ----------------------------------------
   // Helpers
   // ----------------------------------------
   task automatic final_report();
      if (n_errors == 0 && checks_done > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask
   task automatic check(input logic [15:0] got, input logic [15:0] exp);
      checks_done++;
      if (got !== exp) begin
         n_errors++;
         $display("unexpected at %0t: got %h, expected %h", $time, got, exp);
      end
   endtask
   task automatic settle();
      repeat (4) @(posedge clk);
      @(negedge clk);
   endtask
   task automatic rd(input logic [7:0] cmd, input logic [15:0] exp);
      logic [15:0] d;
      logic ok;
      u_ciolr_host.read_word(cmd, d, ok);
      check({15'h0000, ok}, 16'h0001);
      check(d, exp);
   endtask
   task automatic wr(input logic [7:0] cmd, input logic [15:0] d);
      logic ok;
      u_ciolr_host.write_word(cmd, d, ok);
      check({15'h0000, ok}, 16'h0001);
      settle();
   endtask
   // ----------------------------------------
   // Scenarios
   // ----------------------------------------
   task automatic t_reset();
      settle();
      check(lim_ma, 16'h0CB2);
      check(floor_mv, 16'h29E0);
      check(rb_mv, 16'h0BB8);
      rd(CIOLR_OFF_HOST_LIM, 16'h4100);
      rd(CIOLR_OFF_EFF_LIM, 16'h4100);
      rd(CIOLR_OFF_OTG_V, 16'h0000);
      rd(CIOLR_OFF_OTG_I, 16'h0000);
   endtask
   task automatic t_readonly();
      wr(CIOLR_OFF_EFF_LIM, 16'h1234);
      rd(CIOLR_OFF_EFF_LIM, 16'h4100);
      wr(8'h40, 16'h5555);
      rd(8'h40, 16'h0000);
   endtask
   task automatic t_host_limit();
      wr(CIOLR_OFF_HOST_LIM, 16'hFFFF);
      rd(CIOLR_OFF_HOST_LIM, 16'h7F00);
      rd(CIOLR_OFF_EFF_LIM, 16'h7F00);
      check(lim_ma, 16'h18CE);
      wr(CIOLR_OFF_HOST_LIM, 16'h0000);
      check(lim_ma, 16'h0032);
   endtask
   task automatic t_optimizer();
      @(posedge clk);
      ico_code <= 7'h0A;
      ico_act <= 1'b1;
      settle();
      rd(CIOLR_OFF_EFF_LIM, 16'h0A00);
      check(lim_ma, 16'h01F4);
      @(posedge clk);
      ico_code <= 7'h00;
      settle();
      rd(CIOLR_OFF_EFF_LIM, 16'h0000);
      check(lim_ma, 16'h0032);
      @(posedge clk);
      ico_act <= 1'b0;
   endtask
   task automatic t_adapter();
      wr(CIOLR_OFF_HOST_LIM, 16'h1400);
      @(posedge clk);
      adapter_removed <= 1'b1;
      repeat (2) @(posedge clk);
      adapter_removed <= 1'b0;
      rd(CIOLR_OFF_HOST_LIM, 16'h4100);
      settle();
      check(lim_ma, 16'h0CB2);
   endtask
   task automatic t_floor();
      wr(CIOLR_OFF_VFLOOR, 16'h0000);
      check(floor_mv, 16'h0C80);
      wr(CIOLR_OFF_VFLOOR, 16'hE5BF);
      rd(CIOLR_OFF_VFLOOR, 16'h2580);
      check(floor_mv, 16'h2580);
      check({14'h0000, vreg, chg_red}, 16'h0000);
      @(posedge clk);
      meas.input_bus_voltage_mv <= 16'h2328;
      settle();
      check({13'h0000, vreg, chg_red, supp}, 16'h0006);
      @(posedge clk);
      chg_zero <= 1'b1;
      meas.vsys_mv <= 16'h1F40;
      settle();
      check({15'h0000, supp}, 16'h0001);
      @(posedge clk);
      meas.vsys_mv <= 16'h2EE0;
      meas.input_bus_voltage_mv <= 16'h2EE0;
      meas.iin_ma <= 16'h1B58;
      settle();
      check({13'h0000, vreg, chg_red, supp}, 16'h0002);
      @(posedge clk);
      meas.iin_ma <= 16'h03E8;
      chg_zero <= 1'b0;
      settle();
      check({15'h0000, chg_red}, 16'h0000);
   endtask
   task automatic t_boost();
      wr(CIOLR_OFF_OTG_V, 16'hFFFF);
      rd(CIOLR_OFF_OTG_V, 16'h3FFC);
      check(rb_mv, 16'h5050);
      wr(CIOLR_OFF_OTG_V, 16'h07D0);
      check(rb_mv, 16'h14A0);
      @(posedge clk);
      low_rng <= 1'b1;
      settle();
      check(rb_mv, 16'h0FA0);
      wr(CIOLR_OFF_OTG_V, 16'h0100);
      check(rb_mv, 16'h0BB8);
      wr(CIOLR_OFF_OTG_I, 16'hFFFF);
      rd(CIOLR_OFF_OTG_I, 16'h7F00);
      check(rb_ma, 16'h18CE);
   endtask
   task automatic t_ext();
      @(posedge clk);
      ext_en <= 1'b1;
      settle();
      check({15'h0000, ext_act}, 16'h0001);
      @(posedge clk);
      meas.ext_pin_mv <= 16'h1194;
      settle();
      check({15'h0000, ext_act}, 16'h0000);
      @(posedge clk);
      meas.ext_pin_mv <= 16'h07D0;
      ext_en <= 1'b0;
      settle();
      check({15'h0000, ext_act}, 16'h0000);
   endtask
   // ----------------------------------------
   // Clock, reset, sequence, watchdog
   // ----------------------------------------
   initial begin
      clk = 1'b0;
      forever #50 clk = ~clk;
   end
   initial begin
      #3000000;
      n_errors++;
      final_report();
   end
   initial begin
      reset = 1'b1;
      adapter_removed = 1'b0;
      ico_act = 1'b0;
      ico_code = 7'h00;
      ext_en = 1'b0;
      low_rng = 1'b0;
      chg_zero = 1'b0;
      meas = {16'h03E8, 16'h2EE0, 16'h2EE0, 16'h2EE0, 16'h20D0, 16'h07D0};
      repeat (12) @(posedge clk);
      reset <= 1'b0;
      t_reset();
      t_readonly();
      t_host_limit();
      t_optimizer();
      t_adapter();
      t_floor();
      t_boost();
      t_ext();
      final_report();
   end
endmodule
